// ---- bench/lbe_evaluator_monitor.sv ----
`timescale 1ns/1ps
module lbe_evaluator_monitor #(
	parameter int DEPTH = 8,
	parameter int ADDR_W = 10,
	parameter int WORD_W = 16
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic scan_start,
	input wire logic instr_valid,
	input wire lbe_pkg::lbe_op_t instr_op,
	input wire logic [ADDR_W-1:0] instr_addr,
	input wire logic [7:0] instr_bit_bcd,
	input wire logic point_value,
	input wire logic [WORD_W-1:0] word_value,
	input wire logic [(1<<ADDR_W)-1:0] accum_target_mask,
	input wire logic instr_ready,
	input wire logic coil_we,
	input wire logic [ADDR_W-1:0] coil_addr,
	input wire logic coil_data,
	input wire logic [(1<<ADDR_W)-1:0] accum_image,
	input wire logic rung_result,
	input wire logic [$clog2(DEPTH+1)-1:0] stack_level,
	input wire logic stack_overflow,
	input wire logic stack_underflow,
	input wire logic bit_index_error
);
	import lbe_pkg::*;
	logic take;
	assign take = clk_en && instr_valid && instr_ready && !scan_start;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_coil_take;
		take && instr_op == LBE_OP_COIL_OUTPUT;
	endsequence
	sequence s_coil_pulse;
		coil_we ##1 !coil_we;
	endsequence
	a_coil_one_pulse: assert property (s_coil_take |=> s_coil_pulse)
		else $error("coil pulse");
	a_coil_value_addr: assert property (s_coil_take |=> coil_data == $past(rung_result)
		&& coil_addr == $past(instr_addr)) else $error("coil value");
	a_coil_keeps_rung: assert property (s_coil_take |=> $stable(rung_result))
		else $error("rung changed");
	a_load_push: assert property (take && instr_op == LBE_OP_RUNG_START_LOAD
		&& stack_level < DEPTH |=> stack_level == $past(stack_level) + 1'b1
		&& rung_result == $past(point_value)) else $error("push");
	a_overflow_flag: assert property (take && instr_op == LBE_OP_RUNG_START_LOAD
		&& stack_level == DEPTH |=> stack_overflow && stack_level == DEPTH) else $error("ovf");
	a_merge_pops: assert property (take && instr_op inside {LBE_OP_SERIES_BRANCH_MERGE,
		LBE_OP_PARALLEL_BRANCH_MERGE} && stack_level > 1
		|=> stack_level == $past(stack_level) - 1'b1) else $error("merge");
	a_series_and: assert property (take && instr_op == LBE_OP_SERIES_CONTACT
		|=> rung_result == ($past(rung_result) && $past(point_value))) else $error("and");
	a_accum_or: assert property (take && instr_op == LBE_OP_ACCUMULATING_COIL_OUTPUT
		|=> accum_image[$past(instr_addr)] == ($past(accum_image[instr_addr])
		|| $past(rung_result))) else $error("accum");
	a_start_clear: assert property (scan_start && clk_en |=> stack_level == 0
		&& (accum_image & $past(accum_target_mask)) == '0) else $error("start");
endmodule

// ---- bench/lbe_evaluator_tb_top.sv ----
`timescale 1ns/1ps
module lbe_evaluator_tb_top;
	import lbe_pkg::*;
	logic clk_sys = 0, srst = 1, clk_en = 1, scan_start = 0, instr_valid = 0;
	lbe_op_t instr_op = LBE_OP_NOP;
	logic [9:0] instr_addr = '0, coil_addr;
	logic [7:0] instr_bit_bcd = '0, stk = '0;
	logic point_value = 0, instr_ready, coil_we, coil_data, rung_result, ov, un, be;
	logic [15:0] word_value = '0;
	logic [1023:0] accum_target_mask = '0, accum_image, acc = '0;
	logic [3:0] stack_level;
	logic stack_overflow, stack_underflow, bit_index_error;
	int lv = 0, miscompares = 0, checks_done = 0, seed = 32'hc2ffbd16;
	lbe_evaluator #(.DEPTH(8), .ADDR_W(10), .WORD_W(16)) uut (
		.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .scan_start(scan_start),
		.instr_valid(instr_valid), .instr_op(instr_op), .instr_addr(instr_addr),
		.instr_bit_bcd(instr_bit_bcd), .point_value(point_value), .word_value(word_value),
		.accum_target_mask(accum_target_mask), .instr_ready(instr_ready), .coil_we(coil_we),
		.coil_addr(coil_addr), .coil_data(coil_data), .accum_image(accum_image),
		.rung_result(rung_result), .stack_level(stack_level),
		.stack_overflow(stack_overflow), .stack_underflow(stack_underflow),
		.bit_index_error(bit_index_error)
	);
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic start_scan;
		@(posedge clk_sys);
		accum_target_mask <= {32{$random(seed)}};
		scan_start <= 1;
		@(posedge clk_sys);
		scan_start <= 0;
		#1;
		acc &= ~accum_target_mask;
		stk = '0;
		lv = 0;
		{ov, un, be} = 3'h0;
		check(accum_image === acc, 1);
		check({stack_level, stack_overflow, stack_underflow, bit_index_error}, 0);
	endtask
	// one idle cycle between requests keeps clear of the stall after a coil
	task automatic issue(input int o, input logic p, input logic [15:0] w,
		input logic [7:0] b, input logic [9:0] a, input logic en);
		logic v;
		int i;
		@(posedge clk_sys);
		instr_valid <= 1;
		instr_op <= lbe_op_t'(o[3:0]);
		point_value <= p;
		word_value <= w;
		instr_bit_bcd <= b;
		instr_addr <= a;
		clk_en <= en;
		@(posedge clk_sys);
		instr_valid <= 0;
		clk_en <= 1;
		#1;
		i = (b[7:4] * 10 + b[3:0]) % 16;
		v = (o inside {[5:6], [9:10]}) ? w[i] : p;
		if (o inside {2, 4, 6, 8, 10}) v = !v;
		if (en) begin
			if (o inside {[5:6], [9:10]} && (b[7:4] > 9 || b[3:0] > 9 || b > 8'h15)) be = 1;
			case (o) inside
				[1:2]: begin
					ov |= (lv == 8);
					lv = (lv < 8) ? lv + 1 : 8;
					stk = {stk[6:0], v};
				end
				[3:6]: stk[0] |= v;
				[7:10]: stk[0] &= v;
				[11:12]: begin
					if (lv < 2) un = 1;
					else begin
						stk = {1'b0, stk[7:2], (o == 11) ? stk[0] & stk[1] : stk[0] | stk[1]};
						lv--;
					end
				end
				14: acc[a] |= stk[0];
				default: ;
			endcase
		end
		check(rung_result, stk[0]);
		check(stack_level, lv);
		check({stack_overflow, stack_underflow, bit_index_error}, {ov, un, be});
		check(accum_image === acc, 1);
		if (o != 14) check(coil_we, en && o == 13);
		if (en && o == 13) check({instr_ready, coil_addr, coil_data}, {1'b0, a, stk[0]});
	endtask
	task automatic rnd(input int o, input logic en);
		int i;
		i = $unsigned($random(seed)) % 16;
		issue(o, 1'($random(seed)), 16'($random(seed)), 8'((i / 10) * 16 + i % 10),
			10'($unsigned($random(seed)) % 8), en);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		srst <= 0;
		#1;
		check({rung_result, stack_level, coil_we, instr_ready}, 7'h01);
		start_scan();
		repeat (9) rnd(1, 1);
		repeat (8) rnd(11 + $unsigned($random(seed)) % 2, 1);
		issue(9, 1, 16'h0010, 8'h1A, 10'h0, 1);
		issue(0, 1, 16'hFFFF, 8'h03, 10'h1, 1);
		for (int k = 0; k < 2; k++) begin
			issue(1, !k[0], 16'h0, 8'h0, 10'h0, 1);
			issue(13, 0, 16'h0, 8'h0, 10'h5, 1);
		end
		repeat (60) begin
			start_scan();
			rnd(1, 1);
			repeat (10) rnd(1 + $unsigned($random(seed)) % 14, ($random(seed) & 7) != 0);
		end
		final_report();
	end
endmodule
bind lbe_evaluator lbe_evaluator_monitor #(.DEPTH(DEPTH), .ADDR_W(ADDR_W), .WORD_W(WORD_W))
	u_mon (
		.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .scan_start(scan_start),
		.instr_valid(instr_valid), .instr_op(instr_op), .instr_addr(instr_addr),
		.instr_bit_bcd(instr_bit_bcd), .point_value(point_value), .word_value(word_value),
		.accum_target_mask(accum_target_mask), .instr_ready(instr_ready), .coil_we(coil_we),
		.coil_addr(coil_addr), .coil_data(coil_data), .accum_image(accum_image),
		.rung_result(rung_result), .stack_level(stack_level),
		.stack_overflow(stack_overflow), .stack_underflow(stack_underflow),
		.bit_index_error(bit_index_error)
	);

// ---- common/lbe_defines.svh ----
`ifndef LBE_DEFINES_SVH
`define LBE_DEFINES_SVH

`define LBE_STACK_DEPTH 8
`define LBE_OP_W 4
`define LBE_ADDR_W 10
`define LBE_WORD_W 16
`define LBE_BIT_IDX_W 4
`define LBE_BCD_MAX 8'h15

`endif

// ---- common/lbe_pkg.sv ----
`include "lbe_defines.svh"

package lbe_pkg;
	typedef enum logic [3:0] {
		LBE_OP_NOP = 4'h0,
		LBE_OP_RUNG_START_LOAD = 4'h1,
		LBE_OP_RUNG_START_INVERTED = 4'h2,
		LBE_OP_PARALLEL_CONTACT = 4'h3,
		LBE_OP_PARALLEL_INVERTED_CONTACT = 4'h4,
		LBE_OP_PARALLEL_BIT_CONTACT = 4'h5,
		LBE_OP_PARALLEL_INVERTED_BIT_CONTACT = 4'h6,
		LBE_OP_SERIES_CONTACT = 4'h7,
		LBE_OP_SERIES_INVERTED_CONTACT = 4'h8,
		LBE_OP_SERIES_BIT_CONTACT = 4'h9,
		LBE_OP_SERIES_INVERTED_BIT_CONTACT = 4'hA,
		LBE_OP_SERIES_BRANCH_MERGE = 4'hB,
		LBE_OP_PARALLEL_BRANCH_MERGE = 4'hC,
		LBE_OP_COIL_OUTPUT = 4'hD,
		LBE_OP_ACCUMULATING_COIL_OUTPUT = 4'hE
	} lbe_op_t;

	typedef enum logic [1:0] {
		LBE_ST_IDLE = 2'b01,
		LBE_ST_WRITE = 2'b10
	} lbe_state_t;
endpackage

// ---- core/lbe_evaluator.sv ----
`timescale 1ns/1ps
`include "lbe_defines.svh"

// Summary of operation
// RQ1 - parallel contact ORs the referenced point into the rung result
// RQ2 - inverted parallel contact ORs the complemented point into the rung result
// RQ3 - parallel bit contact ORs one BCD-indexed bit 0..15 of a word
// RQ4 - inverted parallel bit contact ORs the complemented selected word bit
// RQ5 - series contact ANDs the referenced point into the rung result
// RQ6 - inverted series contact ANDs the complemented point into the rung result
// RQ7 - series bit contact ANDs one selected bit of a word
// RQ8 - inverted series bit contact ANDs the complemented selected word bit
// RQ9 - series branch merge ANDs two pending branches into one result
// RQ10 - parallel branch merge ORs two pending branches into one result
// RQ11 - sequencer starts both merged branches with rung-start load first
// RQ12 - coil output writes the rung result to the target location
// RQ13 - coil output leaves the rung result unchanged
// RQ14 - last plain coil output to a location sets its final state
// RQ15 - accumulating coil output ORs the rung result into the target
// RQ16 - rung-start load pushes a new value, moving entries down a level
// RQ17 - stack holds eight levels; overflow is reported as an error
// RQ18 - branch merges combine the top two stack levels into one
// RQ19 - accumulating coil targets are cleared at start of each scan
module lbe_evaluator #(
	parameter int DEPTH = `LBE_STACK_DEPTH,
	parameter int ADDR_W = `LBE_ADDR_W,
	parameter int WORD_W = `LBE_WORD_W
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic scan_start,
	input wire logic instr_valid,
	input wire lbe_pkg::lbe_op_t instr_op,
	input wire logic [ADDR_W-1:0] instr_addr,
	input wire logic [7:0] instr_bit_bcd,
	input wire logic point_value,
	input wire logic [WORD_W-1:0] word_value,
	input wire logic [(1<<ADDR_W)-1:0] accum_target_mask,
	output logic instr_ready,
	output logic coil_we,
	output logic [ADDR_W-1:0] coil_addr,
	output logic coil_data,
	output logic [(1<<ADDR_W)-1:0] accum_image,
	output logic rung_result,
	output logic [$clog2(DEPTH+1)-1:0] stack_level,
	output logic stack_overflow,
	output logic stack_underflow,
	output logic bit_index_error
);
	import lbe_pkg::*;

	localparam int LVL_W = $clog2(DEPTH + 1);

	logic [DEPTH-1:0] stack;
	logic [LVL_W-1:0] level;
	lbe_state_t state;
	logic contact;
	logic bad_index;
	logic use_bit;
	logic invert;
	logic accept;
	logic [DEPTH-1:0] next_stack;
	logic [LVL_W-1:0] next_level;
	logic next_overflow;
	logic next_underflow;

	function automatic logic is_bit_op(input lbe_op_t op);
		is_bit_op = (op == LBE_OP_PARALLEL_BIT_CONTACT) ||
			(op == LBE_OP_PARALLEL_INVERTED_BIT_CONTACT) ||
			(op == LBE_OP_SERIES_BIT_CONTACT) ||
			(op == LBE_OP_SERIES_INVERTED_BIT_CONTACT);
	endfunction

	function automatic logic is_inv_op(input lbe_op_t op);
		is_inv_op = (op == LBE_OP_RUNG_START_INVERTED) ||
			(op == LBE_OP_PARALLEL_INVERTED_CONTACT) ||
			(op == LBE_OP_PARALLEL_INVERTED_BIT_CONTACT) ||
			(op == LBE_OP_SERIES_INVERTED_CONTACT) ||
			(op == LBE_OP_SERIES_INVERTED_BIT_CONTACT);
	endfunction

	assign use_bit = is_bit_op(instr_op);
	assign invert = is_inv_op(instr_op);

	lbe_operand_select #(
		.WORD_W(WORD_W)
	) u_sel (
		.point_value(point_value),
		.word_value(word_value),
		.bit_index_bcd(instr_bit_bcd),
		.use_bit(use_bit),
		.invert(invert),
		.contact(contact),
		.bad_index(bad_index)
	);

	// one instruction per enabled cycle; the write state only holds off the next op
	assign instr_ready = (state == LBE_ST_IDLE) && !scan_start;
	assign accept = clk_en && instr_valid && instr_ready;

	always_comb begin
		next_stack = stack;
		next_level = level;
		next_overflow = 1'b0;
		next_underflow = 1'b0;
		case (instr_op)
			LBE_OP_RUNG_START_LOAD, LBE_OP_RUNG_START_INVERTED: begin
				// the old top is kept below; the deepest level drops out on overflow
				next_stack = {stack[DEPTH-2:0], contact}; // RQ16
				if (level == LVL_W'(DEPTH)) begin
					next_overflow = 1'b1; // RQ17
				end else begin
					next_level = level + 1'b1;
				end
			end
			LBE_OP_PARALLEL_CONTACT, LBE_OP_PARALLEL_INVERTED_CONTACT: begin
				next_stack[0] = stack[0] | contact; // RQ1 RQ2
			end
			LBE_OP_PARALLEL_BIT_CONTACT, LBE_OP_PARALLEL_INVERTED_BIT_CONTACT: begin
				next_stack[0] = stack[0] | contact; // RQ3 RQ4
			end
			LBE_OP_SERIES_CONTACT, LBE_OP_SERIES_INVERTED_CONTACT: begin
				next_stack[0] = stack[0] & contact; // RQ5 RQ6
			end
			LBE_OP_SERIES_BIT_CONTACT, LBE_OP_SERIES_INVERTED_BIT_CONTACT: begin
				next_stack[0] = stack[0] & contact; // RQ7 RQ8
			end
			LBE_OP_SERIES_BRANCH_MERGE, LBE_OP_PARALLEL_BRANCH_MERGE: begin
				// a merge with fewer than two levels breaks the sequencer's branch contract
				if (level < LVL_W'(2)) begin
					next_underflow = 1'b1; // RQ11
				end else begin
					next_stack = {1'b0, stack[DEPTH-1:1]}; // RQ18
					if (instr_op == LBE_OP_SERIES_BRANCH_MERGE) begin
						next_stack[0] = stack[0] & stack[1]; // RQ9
					end else begin
						next_stack[0] = stack[0] | stack[1]; // RQ10
					end
					next_level = level - 1'b1;
				end
			end
			default: begin
				// coil outputs leave the stack untouched
				next_stack = stack; // RQ13
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stack <= '0;
			level <= '0;
		end else if (clk_en) begin
			if (scan_start) begin
				stack <= '0;
				level <= '0;
			end else if (accept) begin
				stack <= next_stack;
				level <= next_level;
			end
		end
	end

	// errors are sticky for the scan so the sequencer can abort it
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stack_overflow <= 1'b0;
			stack_underflow <= 1'b0;
			bit_index_error <= 1'b0;
		end else if (clk_en) begin
			if (accept) begin
				stack_overflow <= stack_overflow | next_overflow; // RQ17
				stack_underflow <= stack_underflow | next_underflow;
				bit_index_error <= bit_index_error | bad_index;
			end else if (scan_start) begin
				stack_overflow <= 1'b0;
				stack_underflow <= 1'b0;
				bit_index_error <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= LBE_ST_IDLE;
			coil_we <= 1'b0;
			coil_addr <= '0;
			coil_data <= 1'b0;
		end else if (clk_en) begin
			case (state)
				LBE_ST_IDLE: begin
					coil_we <= 1'b0;
					if (accept && (instr_op == LBE_OP_COIL_OUTPUT)) begin
						// plain writes go out in program order, so the last one wins
						coil_we <= 1'b1; // RQ12 RQ14
						coil_addr <= instr_addr;
						coil_data <= stack[0]; // RQ12
						state <= LBE_ST_WRITE;
					end
				end
				LBE_ST_WRITE: begin
					coil_we <= 1'b0;
					state <= LBE_ST_IDLE;
				end
				default: begin
					coil_we <= 1'b0;
					state <= LBE_ST_IDLE;
				end
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < (1 << ADDR_W); g++) begin : g_accum
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					accum_image[g] <= 1'b0;
				end else if (clk_en) begin
					if (accept && (instr_op == LBE_OP_ACCUMULATING_COIL_OUTPUT) &&
						(instr_addr == ADDR_W'(g))) begin
						accum_image[g] <= (accum_image[g] & ~(scan_start & accum_target_mask[g]))
							| stack[0]; // RQ15
					end else if (scan_start && accum_target_mask[g]) begin
						accum_image[g] <= 1'b0; // RQ19
					end
				end
			end
		end
	endgenerate

	assign rung_result = stack[0];
	assign stack_level = level;
endmodule

// ---- core/lbe_operand_select.sv ----
`timescale 1ns/1ps
`include "lbe_defines.svh"

// picks the contact value: a discrete point, or one bcd-indexed bit of a word
module lbe_operand_select #(
	parameter int WORD_W = `LBE_WORD_W
) (
	input wire logic point_value,
	input wire logic [WORD_W-1:0] word_value,
	input wire logic [7:0] bit_index_bcd,
	input wire logic use_bit,
	input wire logic invert,
	output logic contact,
	output logic bad_index
);
	import lbe_pkg::*;

	logic [4:0] bin_full;
	logic [3:0] bin_index;
	logic raw;

	// worked at five bits so a tens digit of one plus any units digit cannot wrap
	function automatic logic [4:0] bcd_to_bin(input logic [7:0] bcd);
		bcd_to_bin = (5'(bcd[7:4]) * 5'hA) + 5'(bcd[3:0]);
	endfunction

	always_comb begin
		bin_full = bcd_to_bin(bit_index_bcd);
		bin_index = bin_full[3:0];
		bad_index = use_bit && ((bit_index_bcd[3:0] > 4'h9) || (bit_index_bcd > `LBE_BCD_MAX));
		raw = use_bit ? word_value[bin_index] : point_value;
		contact = raw ^ invert;
	end
endmodule
